// [shared/mrb_consts.svh]
/*
 * Constants of the measurement result buffer: register offsets, word layout,
 * depth, reset values and interrupt bits.
 * Assumes inclusion by bare name from the package and the design file.
 */
// Functional notes
// [R1] In buffer mode conversion results are stored and read via buffer word.
// [R2] In buffer mode every conversion result enters the buffer unless it is full with no pop that cycle; none diverted.
// [R3] After reset the word reads full flag clear and empty flag set.
// [R4] Result sits right-justified in bits 11..0; bit 13 reserved.
// [R5] Full flag in bit 15 when all 64 locations hold unread results.
// [R6] Empty flag in bit 14 when no unread result remains.
// [R7] The read returning the last unread result already shows empty.
// [R8] Bit 12 tags source: 0 battery/aux b, 1 aux a/temperature.
// [R9] Auto scan writes aux a, aux b, temperature, skipping unselected.
// [R10] Port scan writes battery, aux a, aux b in that order.
// [R11] Reading the word returns and removes the oldest; writes ignored.
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH

`define MRB_DEPTH 7'h40
`define MRB_AW 6
`define MRB_OFS_DATA 12'h000
`define MRB_OFS_CTRL 12'h004
`define MRB_OFS_STAT 12'h008
`define MRB_OFS_IRQ_STAT 12'h00c
`define MRB_OFS_IRQ_EN 12'h010
`define MRB_OFS_IRQ_CLR 12'h014
`define MRB_BIT_FULL 15
`define MRB_BIT_EMPTY 14
`define MRB_BIT_RSVD 13
`define MRB_BIT_TAG 12
`define MRB_RES_MSB 11
`define MRB_CTRL_BUFMODE 0
`define MRB_CTRL_RST 8'h00
`define MRB_IRQ_W 3
`define MRB_IRQ_DATA 0
`define MRB_IRQ_FULL 1
`define MRB_IRQ_OVF 2

`endif

// [shared/mrb_pkg.sv]
/*
 * Types of the measurement result buffer.
 * Assumes mrb_consts.svh is on the include path.
 */
package mrb_pkg;
`include "mrb_consts.svh"
    typedef enum logic [1:0] {
        MRB_SRC_BATTERY,
        MRB_SRC_AUX_A,
        MRB_SRC_AUX_B,
        MRB_SRC_TEMP
    } mrb_src_t;

    typedef enum logic [1:0] {
        MRB_SCAN_NONE,
        MRB_SCAN_AUTO,
        MRB_SCAN_PORT
    } mrb_scan_t;
endpackage

// [src/mrb_result_buffer.sv]
/*
 * Measurement result buffer: 64-entry FIFO of tagged conversion results,
 * scan-order checking of incoming results, APB register slave and
 * one level interrupt.
 * Assumes the converter delivers results on mclk as one-cycle strobes and
 * that APB is synchronous to mclk.
 */
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "mrb_consts.svh"

module mrb_result_buffer
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_valid,
    input wire logic [11:0] conv_result,
    input wire mrb_src_t conv_source,
    input wire mrb_scan_t scan_mode,
    input wire logic [2:0] auto_select,
    output logic conv_to_buffer,
    output logic scan_order_error,
    output logic irq
);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [12:0] mem_r [0:63];
    logic [`MRB_AW-1:0] wr_ptr_r;
    logic [`MRB_AW-1:0] rd_ptr_r;
    logic [6:0] count_r;
    logic [7:0] ctrl_r;
    logic [`MRB_IRQ_W-1:0] irq_stat_r;
    logic [`MRB_IRQ_W-1:0] irq_en_r;
    logic [1:0] seq_pos_r;
    logic order_err_r;

    logic buf_mode;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic overflow;
    logic acc_cycle;
    logic rd_data_sel;
    logic wr_ctrl_sel;
    logic wr_en_sel;
    logic wr_clr_sel;
    logic addr_ok;
    logic [15:0] word_nxt;
    logic tag_bit;
    logic [1:0] expect_pos;
    logic order_ok;
    logic [1:0] last_auto_pos;
    logic seq_wrap;
    logic rd_first;
    logic rd_wait_r;
    logic evt_data;
    logic evt_full;
    logic evt_ovf;
    logic [`MRB_IRQ_W-1:0] clr_mask;
    logic [31:0] reg_rd_val;

    assign buf_mode = ctrl_r[`MRB_CTRL_BUFMODE];
    assign full = (count_r == `MRB_DEPTH);
    assign empty = (count_r == 7'h00);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign acc_cycle = psel && penable;
    // Data-word reads take one wait state: the popped word is registered
    // at the first access edge and stands while pready is high
    assign rd_first = rd_data_sel && !rd_wait_r;
    assign pready = !rd_first;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_wait_r <= 1'b0;
        end else begin
            rd_wait_r <= rd_first;
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        if (paddr == `MRB_OFS_DATA) begin
            addr_ok = 1'b1;
        end else if (paddr == `MRB_OFS_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr == `MRB_OFS_STAT) begin
            addr_ok = 1'b1;
        end else if (paddr == `MRB_OFS_IRQ_STAT) begin
            addr_ok = 1'b1;
        end else if (paddr == `MRB_OFS_IRQ_EN) begin
            addr_ok = 1'b1;
        end else if (paddr == `MRB_OFS_IRQ_CLR) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pslverr = acc_cycle && !addr_ok;
    assign rd_data_sel = acc_cycle && !pwrite && (paddr == `MRB_OFS_DATA);
    assign wr_ctrl_sel = acc_cycle && pwrite && (paddr == `MRB_OFS_CTRL);
    assign wr_en_sel = acc_cycle && pwrite && (paddr == `MRB_OFS_IRQ_EN);
    assign wr_clr_sel = acc_cycle && pwrite && (paddr == `MRB_OFS_IRQ_CLR);

    // ------------------------------------------------------------
    // Scan order tracking
    // ------------------------------------------------------------
    // Position of a source within the sequence of the current scan kind
    always_comb begin
        expect_pos = 2'h0;
        order_ok = 1'b1;
        case (scan_mode)
            MRB_SCAN_AUTO: begin
                case (conv_source)
                    MRB_SRC_AUX_A: expect_pos = 2'h1;
                    MRB_SRC_AUX_B: expect_pos = 2'h2;
                    MRB_SRC_TEMP: expect_pos = 2'h3;
                    default: expect_pos = 2'h0;
                endcase
                // Sources must climb; unselected ones may be skipped
                order_ok = (expect_pos > seq_pos_r) && (expect_pos != 2'h0) &&
                    auto_select[expect_pos - 2'h1]; // R9
            end
            MRB_SCAN_PORT: begin
                case (conv_source)
                    MRB_SRC_BATTERY: expect_pos = 2'h1;
                    MRB_SRC_AUX_A: expect_pos = 2'h2;
                    MRB_SRC_AUX_B: expect_pos = 2'h3;
                    default: expect_pos = 2'h0;
                endcase
                // Port scan takes no skips: strictly next in line
                order_ok = (expect_pos == seq_pos_r + 2'h1); // R10
            end
            default: begin
                expect_pos = 2'h0;
                order_ok = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Scan end detection
    // ------------------------------------------------------------
    // Highest selected source closes an auto scan; without this a scan
    // that skips temperature would flag the next scan's first result
    always_comb begin
        last_auto_pos = 2'h0;
        if (auto_select[2]) begin
            last_auto_pos = 2'h3;
        end else if (auto_select[1]) begin
            last_auto_pos = 2'h2;
        end else if (auto_select[0]) begin
            last_auto_pos = 2'h1;
        end else begin
            last_auto_pos = 2'h0;
        end
    end

    assign seq_wrap = (expect_pos == 2'h3) ||
        (scan_mode == MRB_SCAN_AUTO && expect_pos == last_auto_pos); // R9

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            seq_pos_r <= 2'h0;
        end else if (conv_valid && scan_mode != MRB_SCAN_NONE) begin
            // Wrap back to the start once the last slot is written
            if (seq_wrap) begin
                seq_pos_r <= 2'h0;
            end else begin
                seq_pos_r <= expect_pos;
            end
        end else if (scan_mode == MRB_SCAN_NONE) begin
            seq_pos_r <= 2'h0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            order_err_r <= 1'b0;
        end else begin
            order_err_r <= conv_valid && !order_ok;
        end
    end

    assign scan_order_error = order_err_r;

    // ------------------------------------------------------------
    // FIFO
    // ------------------------------------------------------------
    // Source tag: battery/aux b give zero, aux a/temperature give one
    assign tag_bit = (conv_source == MRB_SRC_AUX_A) ||
        (conv_source == MRB_SRC_TEMP); // R8
    assign conv_to_buffer = buf_mode; // R2
    assign pop = rd_first && !empty; // R11
    // Results kept in arrival order, so scan order is preserved
    assign push = conv_valid && buf_mode && (!full || pop); // R1 R2
    assign overflow = conv_valid && buf_mode && full && !pop;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= {tag_bit, conv_result}; // R4
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_r <= '0;
        end else if (pop) begin
            rd_ptr_r <= rd_ptr_r + 6'h01;
        end
    end

    // Push and pop together leave the occupancy unchanged
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count_r <= 7'h00;
        end else begin
            if (push && !pop) begin
                count_r <= count_r + 7'h01;
            end else if (pop && !push) begin
                count_r <= count_r - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer word
    // ------------------------------------------------------------
    // Empty flag gives the state after this read, so the draining read says empty; full flag the state before it
    always_comb begin
        word_nxt = 16'h0000;
        word_nxt[`MRB_BIT_FULL] = full; // R5
        word_nxt[`MRB_BIT_EMPTY] = empty || (count_r == 7'h01 && !push); // R6 R7
        word_nxt[`MRB_BIT_RSVD] = 1'b0; // R4
        if (!empty) begin
            word_nxt[`MRB_BIT_TAG:0] = mem_r[rd_ptr_r];
        end
    end

    // ------------------------------------------------------------
    // Control and interrupt registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `MRB_CTRL_RST;
        end else if (wr_ctrl_sel) begin
            ctrl_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_en_r <= '0;
        end else if (wr_en_sel) begin
            irq_en_r <= pwdata[`MRB_IRQ_W-1:0];
        end
    end

    // Events that set the sticky status bits
    assign evt_data = push;
    assign evt_full = push && !pop && (count_r == `MRB_DEPTH - 7'h01);
    assign evt_ovf = overflow;
    assign clr_mask = wr_clr_sel ? pwdata[`MRB_IRQ_W-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r[`MRB_IRQ_DATA] <= evt_data ||
                (irq_stat_r[`MRB_IRQ_DATA] && !clr_mask[`MRB_IRQ_DATA]);
            irq_stat_r[`MRB_IRQ_FULL] <= evt_full ||
                (irq_stat_r[`MRB_IRQ_FULL] && !clr_mask[`MRB_IRQ_FULL]);
            irq_stat_r[`MRB_IRQ_OVF] <= evt_ovf ||
                (irq_stat_r[`MRB_IRQ_OVF] && !clr_mask[`MRB_IRQ_OVF]);
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Plain registers; the data word is handled apart because it pops
    always_comb begin
        reg_rd_val = 32'h0000_0000;
        if (paddr == `MRB_OFS_CTRL) begin
            reg_rd_val = {24'h000000, ctrl_r};
        end else if (paddr == `MRB_OFS_STAT) begin
            reg_rd_val = {25'h0, count_r};
        end else if (paddr == `MRB_OFS_IRQ_STAT) begin
            reg_rd_val = {29'h0, irq_stat_r};
        end else if (paddr == `MRB_OFS_IRQ_EN) begin
            reg_rd_val = {29'h0, irq_en_r};
        end else begin
            reg_rd_val = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= reg_rd_val;
        end else if (rd_first) begin
            // Word captured at the pop edge, shown while pready is high
            prdata <= {16'h0000, word_nxt}; // R3
        end
    end

endmodule

// [verification/mrb_properties.sv]
/* Port checker of the result buffer.
   Assumes binding to mrb_result_buffer and APB on mclk. */
`timescale 1ns/1ns
module mrb_properties
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic conv_valid,
    input wire mrb_src_t conv_source,
    input wire mrb_scan_t scan_mode,
    input wire logic conv_to_buffer,
    input wire logic scan_order_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [6:0] occ_r;
    logic rd, pop, push;
    // First access cycle of a data-word read: the one that pops
    assign rd = psel && penable && !pwrite && paddr == 12'h000 && !pready;
    assign pop = rd && occ_r != 7'h00;
    // Arrival at full is still taken when a pop frees a place
    assign push = conv_valid && conv_to_buffer && (occ_r != 7'h40 || pop);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            occ_r <= 7'h00;
        end else begin
            occ_r <= occ_r + 7'(push) - 7'(pop);
        end
    end
    AST_DRAIN_EMPTY: assert property (rd && occ_r <= 7'h01 && !push |=> prdata[14])
        else $error("empty flag missing on draining read");
    AST_NOT_EMPTY: assert property (rd && occ_r > 7'h01 |=> !prdata[14])
        else $error("empty flag with results left");
    AST_FULL_FLAG: assert property (rd |=> prdata[15] == ($past(occ_r) == 7'h40))
        else $error("full flag wrong");
    AST_RESET_WORD: assert property (rd && occ_r == 7'h00 |=> prdata[15:12] == 4'h4)
        else $error("idle word flags wrong");
    AST_MODE_SRC: assert property ($rose(conv_to_buffer)
        |-> $past(psel && penable && pwrite && paddr == 12'h004 && pwdata[0]))
        else $error("buffer mode without write");
    AST_NO_DROP: assert property (psel && !penable && !pwrite && paddr == 12'h008
        |=> prdata[6:0] == $past(occ_r))
        else $error("stored count wrong");
    AST_AUTO_ORDER: assert property (conv_valid && scan_mode == MRB_SCAN_AUTO
        && conv_source == MRB_SRC_BATTERY |=> scan_order_error)
        else $error("auto scan order slip unflagged");
    AST_PORT_ORDER: assert property (conv_valid && scan_mode == MRB_SCAN_PORT
        && conv_source == MRB_SRC_TEMP |=> scan_order_error)
        else $error("port scan order slip unflagged");
    cover property (rd && occ_r == 7'h40);
    cover property (rd && occ_r == 7'h01);
    cover property (scan_order_error);
endmodule
bind mrb_result_buffer mrb_properties u_chk (.*);

// [verification/mrb_conv_model.sv]
/* Converter model: emits one scan of results on go.
   Assumes mode and sel are steady when go is seen. */
`timescale 1ns/1ns
module mrb_conv_model
    import mrb_pkg::*;
(
    input wire logic mclk,
    input wire logic go,
    input wire logic bad,
    input wire mrb_scan_t mode,
    input wire logic [2:0] sel,
    output logic conv_valid,
    output logic [11:0] conv_result,
    output mrb_src_t conv_source,
    output logic busy
);
    mrb_src_t seq[$];
    initial begin
        conv_valid = 1'b0;
        conv_result = 12'h000;
        conv_source = MRB_SRC_BATTERY;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                busy <= 1'b1;
                seq.delete();
                if (mode == MRB_SCAN_PORT) begin
                    seq = '{MRB_SRC_BATTERY, MRB_SRC_AUX_A, MRB_SRC_AUX_B};
                end else begin
                    for (int i = 0; i < 3; i++) if (sel[i]) seq.push_back(mrb_src_t'(i + 1));
                end
                // Fault on command only: wrong first source
                if (bad) seq[0] = mode == MRB_SCAN_PORT ? MRB_SRC_TEMP : MRB_SRC_BATTERY;
                foreach (seq[i]) begin
                    repeat ($urandom_range(3, 1)) @(posedge mclk);
                    conv_valid <= 1'b1;
                    conv_source <= seq[i];
                    conv_result <= 12'($urandom);
                    @(posedge mclk);
                    conv_valid <= 1'b0;
                    conv_result <= ~conv_result;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// [verification/testbench.sv]
/* Self-checking bench of the result buffer.
   Assumes package, design, checker and model are compiled first. */
`timescale 1ns/1ns
module testbench
    import mrb_pkg::*;
;
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, conv_valid, conv_to_buffer, scan_order_error, irq;
    logic go = 1'b0, bad = 1'b0, busy, err_seen = 1'b0, err_last, bmode = 1'b0;
    logic [11:0] conv_result;
    logic [2:0] auto_select = 3'h1;
    mrb_src_t conv_source;
    mrb_scan_t scan_mode = MRB_SCAN_NONE;
    logic [13:0] exp_q[$];
    int n_mismatch = 0, n_checks = 0;
    always #10 mclk = ~mclk;
    mrb_result_buffer uut (.*);
    mrb_conv_model model (.mclk(mclk), .go(go), .bad(bad), .mode(scan_mode),
        .sel(auto_select), .conv_valid(conv_valid), .conv_result(conv_result),
        .conv_source(conv_source), .busy(busy));
    always @(posedge mclk) begin
        if (conv_valid && bmode && exp_q.size() < 64) exp_q.push_back({conv_source, conv_result});
        if (scan_order_error === 1'b1) err_seen = 1'b1;
    end
    function automatic logic [31:0] exp_word(logic full, logic empty, logic [13:0] e);
        return {16'h0000, full, empty, 1'b0,
            mrb_src_t'(e[13:12]) inside {MRB_SRC_AUX_A, MRB_SRC_TEMP}, e[11:0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        err_last = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so the next call never re-drives psel in this time step
        @(posedge mclk);
    endtask
    task automatic drain(input int n);
        logic full;
        logic [13:0] e;
        repeat (n) begin
            full = exp_q.size() == 64;
            e = exp_q.pop_front();
            apb(1'b0, 12'h000, 32'h0);
            check("word", q[15:0], exp_word(full, exp_q.size() == 0, e));
        end
    endtask
    task automatic scan(input mrb_scan_t m, input logic b);
        scan_mode <= m;
        bad <= b;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy) @(posedge mclk);
    endtask
    // ------
    // Tests
    // ------
    initial begin
        void'($urandom(43));
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0);
        check("reset word", q[15:14], 2'b01);
        apb(1'b1, 12'h000, 32'hfff);
        apb(1'b0, 12'h008, 32'h0);
        check("count", q, 32'h0);
        check("mode", conv_to_buffer, 1'b0);
        apb(1'b0, 12'h0ff, 32'h0);
        check("unmapped", err_last, 1'b1);
        $display("reset test done");
        apb(1'b1, 12'h004, 32'h1);
        bmode = 1'b1;
        check("mode on", conv_to_buffer, 1'b1);
        apb(1'b1, 12'h010, 32'h7);
        auto_select <= 3'($urandom_range(7, 1));
        scan(MRB_SCAN_PORT, 1'b0);
        scan(MRB_SCAN_AUTO, 1'b0);
        check("order flag", err_seen, 1'b0);
        check("irq", irq, 1'b1);
        drain(exp_q.size());
        $display("scan test done");
        apb(1'b1, 12'h014, 32'h7);
        repeat (22) scan(MRB_SCAN_PORT, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        check("count", q, 32'd64);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check("irq status", q[2:0], 3'h7);
        check("irq masked", irq, 1'b0);
        apb(1'b1, 12'h014, 32'h7);
        apb(1'b1, 12'h010, 32'h7);
        apb(1'b0, 12'h00c, 32'h0);
        check("irq cleared", {irq, q[2:0]}, 4'h0);
        drain(64);
        $display("fill test done");
        auto_select <= 3'h7;
        err_seen = 1'b0;
        scan(MRB_SCAN_PORT, 1'b1);
        check("port order flag", err_seen, 1'b1);
        err_seen = 1'b0;
        scan(MRB_SCAN_AUTO, 1'b1);
        check("auto order flag", err_seen, 1'b1);
        drain(exp_q.size());
        $display("order test done");
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
